// File: rtl/phy_err_pkg.sv
package phy_err_pkg;
    // ------------------------------------------------------------
    // register indices (printed offsets are not word multiples)
    // ------------------------------------------------------------
    localparam logic [4:0] IDX_FALSE_CARRIER = 5'h13;
    localparam logic [4:0] IDX_DISCONNECT = 5'h14;
    localparam logic [4:0] IDX_ERROR_FRAME = 5'h15;
    localparam logic [4:0] IDX_SYMBOL_ERROR = 5'h16;
    localparam logic [4:0] IDX_EARLY_END = 5'h17;
    localparam logic [4:0] IDX_SLOW_END = 5'h18;
    localparam logic [4:0] IDX_JABBER = 5'h19;
    localparam logic [4:0] IDX_SPECIAL_LED = 5'h1B;
    localparam logic [4:0] IDX_IRQ_STATUS = 5'h1C;
    localparam logic [4:0] IDX_IRQ_MASK = 5'h1D;
    localparam int ADDR_W = 7;
    localparam int NUM_CNT = 7;
    localparam int FIRST_CNT = 19;
    localparam int CNT_FALSE_CARRIER = 0;
    localparam int CNT_EARLY_END = 4;
    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int SWAP_BIT = 5;
    localparam int NATIVE_BIT = 4;
    localparam int RXJAB_BIT = 3;
    localparam int LEDSEL_LSB = 0;
    localparam logic [15:0] CNT_RESET = 16'h0000;
    localparam logic [15:0] EARLY_END_RESET = 16'h0001;
    localparam logic [2:0] LEDSEL_RESET = 3'h0;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [2:0] SYMBOL_RUN = 3'h6;
    // ------------------------------------------------------------
    // led select codes
    // ------------------------------------------------------------
    localparam logic [2:0] LED_ACT_LINK = 3'h0;
    localparam logic [2:0] LED_SPD_COL = 3'h1;
    localparam logic [2:0] LED_SPD_LINK = 3'h2;
    localparam logic [2:0] LED_ACT_COL = 3'h3;
    localparam logic [2:0] LED_OFF_OFF = 3'h4;
    localparam logic [2:0] LED_OFF_ON = 3'h5;
    localparam logic [2:0] LED_ON_OFF = 3'h6;
endpackage : phy_err_pkg

// File: rtl/phy_error_counters_led_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - false carrier count, read clears it
// - other counters saturate, read clears them
// - count each 100M disconnect event
// - error frame counted once per frame
// - count symbol errors, folded by run
// - six consecutive bad symbols count once
// - premature end count, reset value one
// - count each 10M end of frame
// - count each transmit jabber event
// - control bits 15:6 read zero
// - bit 5 swaps led mapping, keep 0
// - bit 4 reports native mode
// - bit 3 drops carrier in 100M rx jabber
// - led select field picks lamp functions
module phy_error_counters_led_ctrl (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    // register bus, one wait state per access
    input wire logic [phy_err_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    // event pulses, one count per high cycle bar the folded symbol and error-frame counts
    input wire logic i_false_carrier,
    input wire logic i_disconnect,
    input wire logic i_frame_active,
    input wire logic i_symbol_error,
    input wire logic i_early_frame_end,
    input wire logic i_slow_frame_end,
    input wire logic i_jabber_detect,
    // line status levels
    input wire logic i_native_mode,
    input wire logic i_speed_100,
    input wire logic i_rx_jabber,
    input wire logic i_carrier_sense,
    input wire logic i_activity,
    input wire logic i_link_up,
    input wire logic i_collision,
    // gated carrier, lamps and interrupt
    output logic o_carrier_sense,
    output logic o_activity_lamp_n,
    output logic o_link_lamp_n,
    output logic o_irq
);
    localparam int N = phy_err_pkg::NUM_CNT;
    // register map, word index = byte address / 4:
    //   0x13..0x19 event counters in event order
    //   0x1B special control, 0x1C irq status, 0x1D irq mask
    //   every other index reads zero and ignores writes
    //   0x1A is a hole in the map and reads zero
    // only the low 16 bits of any register carry data

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // word index from the byte address
    // the two low address bits select a byte lane and are
    // dropped; any misaligned address hits the same word
    function automatic logic [4:0] word_index(input logic [phy_err_pkg::ADDR_W-1:0] a);
        word_index = a[phy_err_pkg::ADDR_W-1:2];
    endfunction : word_index

    // one counting step, saturating or wrapping
    // false carrier wraps, all other counters stick at full
    function automatic logic [15:0] count_step(input logic [15:0] v, input logic sat);
        if (sat && v == 16'hFFFF) begin
            count_step = v;
        end else begin
            count_step = v + 16'h0001;
        end
    endfunction : count_step

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    // event counters and their next values
    logic [15:0] cnt [N];
    logic [15:0] next_cnt [N];
    // software control fields
    logic [2:0] led_sel;
    logic [2:0] next_led_sel;
    logic swap_map;
    logic next_swap_map;
    logic rxjab_cs_off;
    logic next_rxjab_cs_off;
    // interrupt status and mask
    logic [7:0] irq_status;
    logic [7:0] next_irq_status;
    logic [7:0] irq_mask;
    logic [7:0] next_irq_mask;
    // frame and symbol run tracking
    logic in_frame_err;
    logic next_in_frame_err;
    logic [2:0] sym_run;
    logic [2:0] next_sym_run;
    // bus answer
    logic ack;
    logic next_ack;
    logic [31:0] rdata;
    logic [31:0] next_rdata;
    // combinational helpers
    logic [N-1:0] event_vec;
    logic [N-1:0] rd_clear;
    logic frame_err_evt;
    logic sym_count_evt;
    logic access;
    logic [4:0] idx;
    logic [15:0] ctrl_word;

    // a request is taken only while no answer is pending;
    // ack blocks a second take of the same held request
    assign access = (i_avs_read || i_avs_write) && !ack;
    assign idx = word_index(i_avs_address);
    assign ctrl_word = {10'h000, swap_map, i_native_mode, rxjab_cs_off, led_sel};

    // ------------------------------------------------------------
    // event shaping
    // ------------------------------------------------------------
    // symbol runs and per-frame error detection; a run is
    // broken by any quiet cycle, so six bad symbols spread
    // over gaps count more than once, by intent: only
    // sequential symbols are folded together
    // outside a frame each error counts on its own, since
    // there is no frame to attach it to
    // the error-frame flag drops as soon as the frame ends,
    // ready for the next frame
    always_comb begin
        next_in_frame_err = in_frame_err;
        next_sym_run = sym_run;
        sym_count_evt = 1'b0;
        // one count per six bad symbols
        if (i_symbol_error) begin
            if (sym_run == 3'h0) begin
                sym_count_evt = 1'b1;
            end
            if (sym_run == phy_err_pkg::SYMBOL_RUN - 3'h1) begin
                next_sym_run = 3'h0;
            end else begin
                next_sym_run = sym_run + 3'h1;
            end
        end else begin
            next_sym_run = 3'h0;
        end
        frame_err_evt = 1'b0;
        if ((i_symbol_error || i_early_frame_end) && !in_frame_err) begin
            frame_err_evt = 1'b1;
            next_in_frame_err = i_frame_active;
        end
        if (!i_frame_active) begin
            next_in_frame_err = 1'b0;
        end
    end

    // tracking state; cleared by reset so a frame in flight
    // at reset is not charged to the next one
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            in_frame_err <= 1'b0;
            sym_run <= 3'h0;
        end else begin
            in_frame_err <= next_in_frame_err;
            sym_run <= next_sym_run;
        end
    end

    // ------------------------------------------------------------
    // counters
    // ------------------------------------------------------------
    // bit order of the event vector fixes the counter order
    // and the irq status bit order; keep both in step
    // symbol and error-frame bits come from the shaping above
    // false carrier source
    assign event_vec = {i_jabber_detect, i_slow_frame_end, i_early_frame_end,
                        sym_count_evt, frame_err_evt, i_disconnect, i_false_carrier};

    // a clearing read and an event in the same cycle give a
    // count of one: the read returns the old value and the
    // event lands after the clear, so nothing is lost
    // writes are not decoded here at all, which keeps the
    // counters read-only whatever the byte lanes say
    // reads of the control or irq words never clear counters
    always_comb begin
        for (int k = 0; k < N; k++) begin
            rd_clear[k] = access && i_avs_read && (idx == 5'(phy_err_pkg::FIRST_CNT + k));
            next_cnt[k] = cnt[k];
            if (rd_clear[k]) begin
                next_cnt[k] = phy_err_pkg::CNT_RESET;
            end
            if (event_vec[k]) begin
                next_cnt[k] = count_step(next_cnt[k], k != phy_err_pkg::CNT_FALSE_CARRIER);
            end
        end
    end

    // counters register; only premature end starts at one
    // so software sees a nonzero value before any traffic
    always_ff @(posedge i_sys_clk) begin
        for (int k = 0; k < N; k++) begin
            if (i_sys_rst) begin
                cnt[k] <= (k == phy_err_pkg::CNT_EARLY_END) ? phy_err_pkg::EARLY_END_RESET
                                                            : phy_err_pkg::CNT_RESET;
            end else begin
                cnt[k] <= next_cnt[k];
            end
        end
    end

    // ------------------------------------------------------------
    // control, interrupt and bus
    // ------------------------------------------------------------
    // register writes, interrupt status and read mux
    // only byte lane 0 gates writes: every writable field
    // sits in the low byte, upper lanes are don't care
    // the read mux samples the counter in the take cycle,
    // the same cycle in which the clear is applied
    // status write-one-to-clear runs before the set, so an
    // event in the clearing cycle keeps its bit
    always_comb begin
        next_led_sel = led_sel;
        next_swap_map = swap_map;
        next_rxjab_cs_off = rxjab_cs_off;
        next_irq_mask = irq_mask;
        next_irq_status = irq_status;
        next_ack = access;
        next_rdata = rdata;
        if (access && i_avs_write && i_avs_byteenable[0]) begin
            if (idx == phy_err_pkg::IDX_SPECIAL_LED) begin
                next_led_sel = i_avs_writedata[phy_err_pkg::LEDSEL_LSB +: 3];
                next_swap_map = i_avs_writedata[phy_err_pkg::SWAP_BIT];
                next_rxjab_cs_off = i_avs_writedata[phy_err_pkg::RXJAB_BIT];
            end else if (idx == phy_err_pkg::IDX_IRQ_MASK) begin
                next_irq_mask = i_avs_writedata[7:0];
            end else if (idx == phy_err_pkg::IDX_IRQ_STATUS) begin
                // write one to clear
                next_irq_status = irq_status & ~i_avs_writedata[7:0];
            end
        end
        // set wins over clear
        next_irq_status = next_irq_status | {1'b0, event_vec};
        if (access && i_avs_read) begin
            next_rdata = 32'h0000_0000;
            if (idx >= 5'(phy_err_pkg::FIRST_CNT) && idx < 5'(phy_err_pkg::FIRST_CNT + N)) begin
                next_rdata[15:0] = cnt[3'(idx - 5'(phy_err_pkg::FIRST_CNT))];
            end else if (idx == phy_err_pkg::IDX_SPECIAL_LED) begin
                next_rdata[15:0] = ctrl_word;
            end else if (idx == phy_err_pkg::IDX_IRQ_STATUS) begin
                next_rdata[7:0] = irq_status;
            end else if (idx == phy_err_pkg::IDX_IRQ_MASK) begin
                next_rdata[7:0] = irq_mask;
            end
        end
    end

    // control, interrupt and bus registers
    // readdata is held between reads, so a late sample by
    // the master still sees the last answered word
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            led_sel <= phy_err_pkg::LEDSEL_RESET;
            swap_map <= 1'b0;
            rxjab_cs_off <= 1'b0;
            irq_mask <= phy_err_pkg::MASK_RESET;
            irq_status <= phy_err_pkg::MASK_RESET;
            ack <= 1'b0;
            rdata <= 32'h0000_0000;
        end else begin
            led_sel <= next_led_sel;
            swap_map <= next_swap_map;
            rxjab_cs_off <= next_rxjab_cs_off;
            irq_mask <= next_irq_mask;
            irq_status <= next_irq_status;
            ack <= next_ack;
            rdata <= next_rdata;
        end
    end

    // one wait cycle, then answer
    // waitrequest is combinational from ack, so an idle bus
    // shows it high and no answer can come early
    assign o_avs_waitrequest = !ack;
    assign o_avs_readdata = rdata;
    assign o_irq = |(irq_status & irq_mask);

    // ------------------------------------------------------------
    // carrier sense and lamps
    // ------------------------------------------------------------
    // lamp functions before the swap mux, active high
    logic lamp_a;
    logic lamp_b;
    logic next_lamp_a;
    logic next_lamp_b;
    logic next_cs;

    // carrier gating and lamp function decode
    // codes four to seven ignore the line state entirely so
    // a board can test its lamps without a link
    // code seven lights both lamps
    always_comb begin
        // cut carrier in 100M rx jabber
        next_cs = i_carrier_sense && !(rxjab_cs_off && i_speed_100 && i_rx_jabber);
        case (led_sel)
            phy_err_pkg::LED_ACT_LINK: begin
                next_lamp_a = i_activity;
                next_lamp_b = i_link_up;
            end
            phy_err_pkg::LED_SPD_COL: begin
                next_lamp_a = i_speed_100;
                next_lamp_b = i_collision;
            end
            phy_err_pkg::LED_SPD_LINK: begin
                next_lamp_a = i_speed_100;
                next_lamp_b = i_link_up;
            end
            phy_err_pkg::LED_ACT_COL: begin
                next_lamp_a = i_activity;
                next_lamp_b = i_collision;
            end
            phy_err_pkg::LED_OFF_OFF: begin
                next_lamp_a = 1'b0;
                next_lamp_b = 1'b0;
            end
            phy_err_pkg::LED_OFF_ON: begin
                next_lamp_a = 1'b0;
                next_lamp_b = 1'b1;
            end
            phy_err_pkg::LED_ON_OFF: begin
                next_lamp_a = 1'b1;
                next_lamp_b = 1'b0;
            end
            default: begin
                next_lamp_a = 1'b1;
                next_lamp_b = 1'b1;
            end
        endcase
    end

    // lamp and carrier registers; reset leaves lamps dark
    // and carrier low until the first real sample
    always_ff @(posedge i_sys_clk) begin
        if (i_sys_rst) begin
            lamp_a <= 1'b0;
            lamp_b <= 1'b0;
            o_carrier_sense <= 1'b0;
        end else begin
            lamp_a <= next_lamp_a;
            lamp_b <= next_lamp_b;
            o_carrier_sense <= next_cs;
        end
    end

    // the swap mux is combinational: a swap write moves the
    // lamps at once, one cycle before a new code arrives
    // swap lamp mapping when set
    // lamps are active low: a lit lamp drives zero
    assign o_activity_lamp_n = !(swap_map ? lamp_b : lamp_a);
    assign o_link_lamp_n = !(swap_map ? lamp_a : lamp_b);
endmodule : phy_error_counters_led_ctrl

// File: verif/phy_err_checker.sv
`timescale 1ns/100ps
// --------------------------------
// bus, control and lamp checks
// --------------------------------
module phy_err_checker (
    input wire logic i_sys_clk,
    input wire logic i_sys_rst,
    input wire logic [phy_err_pkg::ADDR_W-1:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    input wire logic [31:0] o_avs_readdata,
    input wire logic o_avs_waitrequest,
    input wire logic i_native_mode,
    input wire logic i_speed_100,
    input wire logic i_rx_jabber,
    input wire logic i_carrier_sense,
    input wire logic i_activity,
    input wire logic i_link_up,
    input wire logic o_carrier_sense,
    input wire logic o_activity_lamp_n,
    input wire logic o_link_lamp_n
);
    logic [5:0] ctl;
    logic [5:0] next_ctl;
    logic [4:0] idx;
    logic rd_done;
    logic cs_exp;
    // word index, read completion and expected carrier
    assign idx = i_avs_address[6:2];
    assign rd_done = i_avs_read && !o_avs_waitrequest;
    assign cs_exp = i_carrier_sense && !(ctl[3] && i_speed_100 && i_rx_jabber);
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_sys_rst);
    // shadow updates at the take edge, as the design does
    always_comb begin
        next_ctl = ctl;
        if (i_sys_rst) begin
            next_ctl = 6'h00;
        end else if (i_avs_write && o_avs_waitrequest && idx == 5'h1B && i_avs_byteenable[0]) begin
            next_ctl = i_avs_writedata[5:0];
        end
    end
    always_ff @(posedge i_sys_clk) begin
        ctl <= next_ctl;
    end
    AST_ONE_WAIT: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest)
        else $error("request not answered after one wait cycle");
    AST_IDLE_WAIT: assert property (!i_avs_read && !i_avs_write |-> o_avs_waitrequest)
        else $error("waitrequest low while idle");
    AST_UPPER_ZERO: assert property (rd_done |-> o_avs_readdata[31:16] == 16'h0000)
        else $error("upper read lanes not zero");
    AST_CTRL_RSVD: assert property (rd_done && idx == 5'h1B |-> o_avs_readdata[15:6] == 10'h000)
        else $error("reserved control bits not zero");
    AST_NATIVE: assert property (rd_done && idx == 5'h1B |-> o_avs_readdata[4] == $past(i_native_mode))
        else $error("mode bit does not follow strap");
    AST_CS_GATE: assert property (!$past(i_sys_rst) |-> o_carrier_sense == $past(cs_exp))
        else $error("carrier sense gating wrong");
    AST_LED_FIXED: assert property ($past(ctl[2]) && !$past(i_sys_rst) |->
        {o_activity_lamp_n, o_link_lamp_n} == ~(ctl[5] ? {$past(ctl[0]), $past(ctl[1])} : {$past(ctl[1]), $past(ctl[0])}))
        else $error("fixed lamp code drives wrong levels");
    AST_LED_LIVE: assert property (!ctl[5] && $past(ctl[2:0]) == 3'h0 && !$past(i_sys_rst) |->
        o_activity_lamp_n == !$past(i_activity) && o_link_lamp_n == !$past(i_link_up))
        else $error("activity or link lamp not following input");
    AST_UNMAPPED: assert property (rd_done && (idx < 5'h13 || idx == 5'h1A || idx > 5'h1D) |->
        o_avs_readdata == 32'h00000000) else $error("unmapped read not zero");
    cover property (rd_done && idx == 5'h1B);
    cover property (ctl[3] && i_speed_100 && i_rx_jabber && i_carrier_sense);
    cover property (ctl[5] && ctl[2]);
endmodule : phy_err_checker
bind phy_error_counters_led_ctrl phy_err_checker chk (.i_sys_clk, .i_sys_rst, .i_avs_address, .i_avs_read,
    .i_avs_write, .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .i_native_mode,
    .i_speed_100, .i_rx_jabber, .i_carrier_sense, .i_activity, .i_link_up, .o_carrier_sense,
    .o_activity_lamp_n, .o_link_lamp_n);

// File: verif/test_phy_error_counters_led_ctrl.sv
`timescale 1ns/100ps
module test_phy_error_counters_led_ctrl;
    logic clk, rst, rd, wr, fa, nat, spd, rxj, cs, act, lnk, col, wreq, ocs, alamp_n, llamp_n, irq;
    logic [phy_err_pkg::ADDR_W-1:0] addr;
    logic [31:0] wdata, rdata;
    logic [3:0] be;
    logic [5:0] ev;
    int errors = 0;
    int num_checks = 0;
    phy_error_counters_led_ctrl dut (.i_sys_clk(clk), .i_sys_rst(rst), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_false_carrier(ev[0]), .i_disconnect(ev[1]), .i_frame_active(fa),
        .i_symbol_error(ev[2]), .i_early_frame_end(ev[3]), .i_slow_frame_end(ev[4]), .i_jabber_detect(ev[5]),
        .i_native_mode(nat), .i_speed_100(spd), .i_rx_jabber(rxj), .i_carrier_sense(cs), .i_activity(act),
        .i_link_up(lnk), .i_collision(col), .o_carrier_sense(ocs), .o_activity_lamp_n(alamp_n),
        .o_link_lamp_n(llamp_n), .o_irq(irq));
    // --------------------------------
    // shared tasks
    // --------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic close_out;
        if (errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : close_out
    // one bus cycle; pe pulses events on the take edge
    task automatic bus(input logic w, input logic [6:0] a, input logic [15:0] d, input logic [5:0] pe,
        output logic [31:0] q);
        int n;
        n = 0;
        rd <= !w;
        wr <= w;
        addr <= a;
        wdata <= {16'h0000, d};
        ev <= pe;
        do begin
            @(posedge clk);
            ev <= 6'h00;
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            errors++;
            close_out();
        end
        @(posedge clk);
    endtask : bus
    task automatic rdc(input logic [6:0] a, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, a, 16'h0000, 6'h00, q);
        check(q, e);
    endtask : rdc
    task automatic wrq(input logic [6:0] a, input logic [15:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, 6'h00, q);
    endtask : wrq
    // consecutive event cycles, then one quiet cycle
    task automatic pulse(input logic [5:0] m, input int n);
        repeat (n) begin
            ev <= m;
            @(posedge clk);
        end
        ev <= 6'h00;
        @(posedge clk);
    endtask : pulse
    // --------------------------------
    // scenarios
    // --------------------------------
    task automatic t_counts;
        logic [6:0] cad [4] = '{7'h4C, 7'h50, 7'h60, 7'h64};
        logic [5:0] cev [4] = '{6'h01, 6'h02, 6'h10, 6'h20};
        logic [31:0] q;
        for (int k = 0; k < 7; k++) rdc(7'h4C + 7'(4 * k), k == 4 ? 32'h1 : 32'h0);
        rdc(7'h5C, 32'h0);
        rdc(7'h6C, 32'h10);
        for (int k = 0; k < 4; k++) begin
            pulse(cev[k], k + 3);
            wrq(cad[k], 16'h5A5A);
            rdc(cad[k], 32'(k + 3));
            rdc(cad[k], 32'h0);
        end
        bus(1'b0, 7'h64, 16'h0000, 6'h20, q);
        check(q, 32'h0);
        rdc(7'h64, 32'h1);
    endtask : t_counts
    task automatic t_symbol;
        fa <= 1'b1;
        pulse(6'h04, 13);
        pulse(6'h04, 6);
        pulse(6'h08, 1);
        fa <= 1'b0;
        @(posedge clk);
        rdc(7'h58, 32'h4);
        rdc(7'h54, 32'h1);
        rdc(7'h5C, 32'h1);
        pulse(6'h02, 65537);
        rdc(7'h50, 32'hFFFF);
    endtask : t_symbol
    task automatic t_ctrl;
        logic ao, lo;
        logic [1:0] e2;
        for (int v = 0; v < 16; v++) begin
            wrq(7'h6C, {10'h000, v[3], 2'b00, v[2:0]});
            ao = v[2] ? v[1] : (v[1] ^ v[0] ? spd : act);
            lo = v[2] ? v[0] : (v[0] ? col : lnk);
            e2 = v[3] ? ~{lo, ao} : ~{ao, lo};
            check({alamp_n, llamp_n}, e2);
        end
        wrq(7'h6C, 16'hFFFF);
        rdc(7'h6C, 32'h3F);
        cs <= 1'b1;
        spd <= 1'b1;
        rxj <= 1'b1;
        repeat (2) @(posedge clk);
        check(ocs, 1'b0);
        rxj <= 1'b0;
        repeat (2) @(posedge clk);
        check(ocs, 1'b1);
        wrq(7'h6C, 16'h0000);
    endtask : t_ctrl
    // sticky status, mask and write-one-to-clear
    task automatic t_irq;
        wrq(7'h70, 16'h007F);
        wrq(7'h74, 16'h0002);
        check(irq, 1'b0);
        pulse(6'h02, 1);
        check(irq, 1'b1);
        rdc(7'h70, 32'h2);
        wrq(7'h74, 16'h0000);
        check(irq, 1'b0);
        wrq(7'h74, 16'h0002);
        be <= 4'h0;
        wrq(7'h70, 16'h0002);
        be <= 4'hF;
        check(irq, 1'b1);
        wrq(7'h70, 16'h0002);
        check(irq, 1'b0);
        rdc(7'h78, 32'h0);
    endtask : t_irq
    // free-running clock, 8 ns period
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        {rd, wr, fa, spd, rxj, cs, col} = 7'h00;
        {nat, act, lnk} = 3'h7;
        addr = 7'h00;
        wdata = 32'h00000000;
        be = 4'hF;
        ev = 6'h00;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        t_counts();
        t_symbol();
        t_ctrl();
        t_irq();
        close_out();
    end
endmodule : test_phy_error_counters_led_ctrl
